// ==== dfps_cfg.svh ====
`ifndef DFPS_CFG_SVH
`define DFPS_CFG_SVH

// select register offsets, one per port
`define DFPS_SEL0_OFS 8'h48
`define DFPS_SEL1_OFS 8'h50
`define DFPS_SEL_RST 16'h0000
// writable bits: rewind (b12) is write-only, b5..b4 reserved
`define DFPS_SEL_WMASK 16'hefcf

// field positions of the select register
`define DFPS_B_BURST 15
`define DFPS_B_METH_HI 14
`define DFPS_B_METH_LO 13
`define DFPS_B_POINTER_REWIND 12
`define DFPS_B_ACKPOL 11
`define DFPS_B_REQPOL 10
`define DFPS_B_READY_TIMING_MODE 9
`define DFPS_B_EN 8
`define DFPS_B_BYTE_ORDER_SELECT 7
`define DFPS_B_NARROW 6
`define DFPS_B_EP_HI 3
`define DFPS_B_EP_LO 0

// endpoint codes that select an endpoint
`define DFPS_EP_FIRST 4'h1
`define DFPS_EP_LAST 4'h6

// link pin idle levels {tc, cs_n, wr_n, rd_n, ack}
`define DFPS_PIN_IDLE 5'h0f

// timing of the far end strobes
`define DFPS_CLK_NS 100
`define DFPS_STROBE_NS 500
`define DFPS_GAP_NS 400
`define DFPS_STROBE_CYC ((`DFPS_STROBE_NS + `DFPS_CLK_NS - 1) / `DFPS_CLK_NS)
`define DFPS_GAP_CYC ((`DFPS_GAP_NS + `DFPS_CLK_NS - 1) / `DFPS_CLK_NS)

`endif

// ==== dfps_pkg.sv ====
package dfps_pkg;

    // strobe qualification methods
    typedef enum logic [1:0] {
        DFPS_M_ACKRW = 2'h0,
        DFPS_M_ACK = 2'h1,
        DFPS_M_CSRW = 2'h2,
        DFPS_M_RSVD = 2'h3
    } dfps_method_e;

    // far end transfer states
    typedef enum logic [3:0] {
        DFPS_H_IDLE = 4'h1,
        DFPS_H_SETUP = 4'h2,
        DFPS_H_STROBE = 4'h4,
        DFPS_H_GAP = 4'h8
    } dfps_hstate_e;

    // select register layout, msb first
    typedef struct packed {
        logic burst;
        dfps_method_e method;
        logic pointer_rewind;
        logic ack_pol;
        logic req_pol;
        logic ready_timing_mode;
        logic en;
        logic byte_order_select;
        logic narrow;
        logic [1:0] rsvd;
        logic [3:0] ep;
    } dfps_sel_s;

endpackage

// ==== dfps_if.sv ====
interface dfps_if;
    logic req;
    logic ack;
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic tc;
    logic [15:0] h_data;
    logic h_oe;
    logic [15:0] d_data;
    logic d_oe;
    logic [15:0] bus;

    // shared data bus level worked out from the two enables
    assign bus = d_oe ? d_data : (h_oe ? h_data : 16'h0000);

    modport dev (
        output req, d_data, d_oe,
        input ack, rd_n, wr_n, cs_n, tc, bus
    );
    modport host (
        input req, bus,
        output ack, rd_n, wr_n, cs_n, tc, h_data, h_oe
    );
endinterface

// ==== dfps_fifo.sv ====
module dfps_fifo #(
    parameter int W = 17,
    parameter int D = 8
) (
    input logic clk_i,
    input logic sys_rst_i,
    input logic in_valid_i,
    output logic in_ready_o,
    input logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic push;
    logic pop;

    // depth must be a power of two so the pointers wrap by themselves
    if (D < 2 || (1 << AW) != D) begin : g_chk
        $error("dfps_fifo: depth must be a power of two of at least 2");
    end

    // honest full and empty
    assign in_ready_o = cnt != (AW + 1)'(D);
    assign out_valid_o = cnt != '0;
    assign out_data_o = mem[rp];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp] <= in_data_i;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
            if (push && !pop) begin
                cnt <= cnt + 1'b1;
            end else if (pop && !push) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule

// ==== dfps_host.sv ====
`include "dfps_cfg.svh"

module dfps_host #(
    parameter int STROBE = `DFPS_STROBE_CYC,
    parameter int GAP = `DFPS_GAP_CYC
) (
    input logic clk_i,
    input logic sys_rst_i,
    dfps_if.host lnk,
    input logic ack_pol_i,
    input logic req_pol_i,
    input logic cmd_valid_i,
    input logic cmd_write_i,
    input logic [15:0] cmd_data_i,
    input logic cmd_last_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [15:0] rsp_data_o
);
    dfps_pkg::dfps_hstate_e st;
    logic [3:0] cnt;
    logic wr;
    logic last;
    logic [15:0] data;
    logic req_on;
    logic ack_on;
    logic strobe;
    logic busy;

    // the device needs two cycles to see a strobe and one to answer
    if (STROBE < 4 || STROBE > 16 || GAP < 3 || GAP > 16) begin : g_chk
        $error("dfps_host: strobe or gap length out of range");
    end

    assign req_on = ~(lnk.req ^ req_pol_i);
    assign cmd_ready_o = (st == dfps_pkg::DFPS_H_IDLE) & req_on;
    assign ack_on = (st == dfps_pkg::DFPS_H_SETUP) | (st == dfps_pkg::DFPS_H_STROBE);
    assign strobe = st == dfps_pkg::DFPS_H_STROBE;
    assign busy = st != dfps_pkg::DFPS_H_IDLE;

    // pins: ack and chip select frame the strobe, data held through the gap
    assign lnk.ack = ~(ack_on ^ ack_pol_i);
    assign lnk.cs_n = ~ack_on;
    assign lnk.rd_n = ~(strobe & ~wr);
    assign lnk.wr_n = ~(strobe & wr);
    assign lnk.tc = last & wr & busy;
    assign lnk.h_oe = wr & busy;
    assign lnk.h_data = data;

    // one transfer per command, started only while the request stands
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st <= dfps_pkg::DFPS_H_IDLE;
            cnt <= 4'h0;
            wr <= 1'b0;
            last <= 1'b0;
            data <= 16'h0000;
        end else begin
            unique case (st)
                dfps_pkg::DFPS_H_IDLE: begin
                    if (cmd_valid_i && cmd_ready_o) begin
                        wr <= cmd_write_i;
                        last <= cmd_last_i;
                        data <= cmd_data_i;
                        st <= dfps_pkg::DFPS_H_SETUP;
                    end
                end
                dfps_pkg::DFPS_H_SETUP: begin
                    cnt <= 4'(STROBE - 1);
                    st <= dfps_pkg::DFPS_H_STROBE;
                end
                dfps_pkg::DFPS_H_STROBE: begin
                    if (cnt == 4'h0) begin
                        cnt <= 4'(GAP - 1);
                        st <= dfps_pkg::DFPS_H_GAP;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                dfps_pkg::DFPS_H_GAP: begin
                    if (cnt == 4'h0) begin
                        wr <= 1'b0;
                        last <= 1'b0;
                        st <= dfps_pkg::DFPS_H_IDLE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
            endcase
        end
    end

    // read data taken in the last strobe cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 16'h0000;
        end else begin
            rsp_valid_o <= strobe & ~wr & (cnt == 4'h0);
            if (strobe && !wr && cnt == 4'h0) begin
                rsp_data_o <= lnk.bus;
            end
        end
    end
endmodule

// ==== dfps_dev.sv ====
`include "dfps_cfg.svh"

// Contract
// - bit 15 picks cycle-steal or burst request
// - cycle-steal: request per word, drop on access
// - burst: request held until buffer done
// - terminal count ends write, short packet allowed
// - two-bit method field picks strobe qualification
// - method 00: ack plus read/write strobes
// - method 01: ack alone, write on ack release
// - method 10: chip select plus read/write strobes
// - wrong-direction data accesses are ignored
// - rewind clears read pointer of valid receive buffer
// - rewind clears write pointer of unfilled transmit buffer
// - bit 11 sets acknowledge polarity
// - bit 10 sets request polarity
// - bit 8 enables the request output
// - mode 0 receive: ready after all data read
// - buffer clear ends ready per ready-clear mode
// - mode 1: ready set like unassigned endpoints
// - mode 0 transmit: ready never set
// - bit 7 selects byte order
// - bit 6 selects 8-bit or 16-bit access
// - endpoint codes 1..6 valid, others select none
// - 8-bit if port or endpoint width bit set
// - upper byte ignored in 8-bit mode
module dfps_dev #(
    parameter int PORT = 0,
    parameter int MAXP = 64,
    parameter int FDEPTH = 8
) (
    input logic clk_i,
    input logic sys_rst_i,
    dfps_if.dev lnk,
    input logic reg_we_i,
    input logic [7:0] reg_addr_i,
    input logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    input logic [6:0] ep_dir_i,
    input logic [6:0] ep_narrow_i,
    input logic buffer_valid_i,
    input logic [10:0] port_receive_length_i,
    input logic buffer_clear_i,
    input logic ready_clear_mode_i,
    input logic ready_flag_clr_i,
    input logic sie_ready_evt_i,
    output logic buffer_ready_flag_o,
    output logic write_done_o,
    output logic rewind_o,
    input logic [15:0] rx_data_i,
    output logic rx_ready_o,
    output logic tx_valid_o,
    input logic tx_ready_i,
    output logic [16:0] tx_data_o
);
    localparam logic [7:0] SEL_OFS = (PORT == 0) ? `DFPS_SEL0_OFS : `DFPS_SEL1_OFS;
    localparam logic [10:0] MAXP_B = 11'(MAXP);

    dfps_pkg::dfps_sel_s sel;
    logic hit;
    logic pointer_rewind_wr;
    logic ep_ok;
    logic dir;
    logic narrow;
    logic [4:0] s1;
    logic [4:0] s2;
    logic ack_act;
    logic rs_raw;
    logic ws_raw;
    logic rs_q;
    logic ws_q;
    logic rd_end;
    logic wr_end;
    logic rx_side;
    logic tx_side;
    logic rx_acc;
    logic rx_done;
    logic tx_acc;
    logic rd_take;
    logic wr_take;
    logic wr_last;
    logic pointer_rewind_ok;
    logic [10:0] ptr;
    logic [10:0] step;
    logic [10:0] next_ptr;
    logic [15:0] wfmt;
    logic [15:0] dd;
    logic f_in_ready;
    logic req_act;
    logic seen;
    logic rdy_set;
    logic rdy_clr;

    if (PORT > 1 || MAXP < 2 || MAXP > 1023 || FDEPTH < 2) begin : g_chk
        $error("dfps_dev: port, packet size or fifo depth out of range");
    end

    // select register, rewind reads back as zero
    assign hit = reg_we_i && (reg_addr_i == SEL_OFS);
    assign pointer_rewind_wr = hit & reg_wdata_i[`DFPS_B_POINTER_REWIND];
    assign reg_rdata_o = (reg_addr_i == SEL_OFS) ? sel : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sel <= `DFPS_SEL_RST;
        end else if (hit) begin
            sel <= reg_wdata_i & `DFPS_SEL_WMASK;
        end
    end

    // endpoint decode and effective width
    assign ep_ok = (sel.ep >= `DFPS_EP_FIRST) && (sel.ep <= `DFPS_EP_LAST);
    assign dir = ep_ok & ep_dir_i[sel.ep[2:0]];
    assign narrow = sel.narrow | (ep_ok & ep_narrow_i[sel.ep[2:0]]);
    assign rx_side = ep_ok & ~dir;
    assign tx_side = ep_ok & dir;

    // two-stage synchroniser on the link pins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1 <= `DFPS_PIN_IDLE;
            s2 <= `DFPS_PIN_IDLE;
        end else begin
            s1 <= {lnk.tc, lnk.cs_n, lnk.wr_n, lnk.rd_n, lnk.ack};
            s2 <= s1;
        end
    end

    assign ack_act = ~(s2[0] ^ sel.ack_pol);

    // strobe qualification per method
    always_comb begin
        rs_raw = 1'b0;
        ws_raw = 1'b0;
        unique case (sel.method)
            dfps_pkg::DFPS_M_ACKRW: begin
                rs_raw = ack_act & ~s2[1];
                ws_raw = ack_act & ~s2[2];
            end
            dfps_pkg::DFPS_M_ACK: begin
                rs_raw = ack_act & ~dir;
                ws_raw = ack_act & dir;
            end
            dfps_pkg::DFPS_M_CSRW: begin
                rs_raw = ~s2[3] & ~s2[1];
                ws_raw = ~s2[3] & ~s2[2];
            end
            dfps_pkg::DFPS_M_RSVD: begin
                rs_raw = 1'b0;
                ws_raw = 1'b0;
            end
        endcase
    end

    // strobe ends act once each
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rs_q <= 1'b0;
            ws_q <= 1'b0;
        end else begin
            rs_q <= rs_raw;
            ws_q <= ws_raw;
        end
    end

    assign rd_end = rs_q & ~rs_raw;
    assign wr_end = ws_q & ~ws_raw;

    // buffer accessibility and pointer step
    assign step = narrow ? 11'h001 : 11'h002;
    assign next_ptr = ptr + step;
    assign rx_acc = rx_side & buffer_valid_i & (ptr < port_receive_length_i);
    assign rx_done = rx_side & buffer_valid_i & (ptr >= port_receive_length_i);
    assign tx_acc = tx_side & ~buffer_valid_i & (ptr < MAXP_B);
    assign rd_take = rd_end & rx_acc;
    assign wr_take = wr_end & tx_acc & f_in_ready;
    assign wr_last = wr_take & (s2[4] | (next_ptr >= MAXP_B));
    assign pointer_rewind_ok = pointer_rewind_wr & ((rx_side & buffer_valid_i) | (tx_side & ~buffer_valid_i));

    // buffer pointer: clear and rewind beat an advance
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || buffer_clear_i || wr_last) begin
            ptr <= 11'h000;
        end else if (pointer_rewind_ok) begin
            ptr <= 11'h000;
        end else if (rd_take || wr_take) begin
            ptr <= next_ptr;
        end
    end

    // one-cycle notices to the buffer logic
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            write_done_o <= 1'b0;
            rewind_o <= 1'b0;
            rx_ready_o <= 1'b0;
        end else begin
            write_done_o <= wr_last;
            rewind_o <= pointer_rewind_ok;
            rx_ready_o <= rd_take;
        end
    end

    // byte lanes of written data
    always_comb begin
        if (narrow) begin
            wfmt = {8'h00, lnk.bus[7:0]};
        end else if (sel.byte_order_select) begin
            wfmt = {lnk.bus[7:0], lnk.bus[15:8]};
        end else begin
            wfmt = lnk.bus;
        end
    end

    // read data register and drive enable
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dd <= 16'h0000;
        end else if (narrow) begin
            dd <= {8'h00, rx_data_i[7:0]};
        end else if (sel.byte_order_select) begin
            dd <= {rx_data_i[7:0], rx_data_i[15:8]};
        end else begin
            dd <= rx_data_i;
        end
    end

    assign lnk.d_data = dd;
    assign lnk.d_oe = rs_raw & rx_side;

    // transmit words queue toward the serial side
    dfps_fifo #(
        .W(17),
        .D(FDEPTH)
    ) dfps_fifo_i (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(wr_take),
        .in_ready_o(f_in_ready),
        .in_data_i({narrow, wfmt}),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(tx_data_o)
    );

    // request: burst holds, cycle steal drops while a strobe is seen
    assign req_act = sel.en & (rx_acc | (tx_acc & f_in_ready))
        & (sel.burst | ~(rs_raw | ws_raw | rs_q | ws_q));

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lnk.req <= 1'b1;
        end else begin
            lnk.req <= ~(req_act ^ sel.req_pol);
        end
    end

    // ready flag: mode 0 on receive after last read, mode 1 from serial side
    assign rdy_set = (~sel.ready_timing_mode & rx_done & ~seen)
        | (sel.ready_timing_mode & ep_ok & sie_ready_evt_i);
    assign rdy_clr = (buffer_clear_i & ~ready_clear_mode_i)
        | (ready_flag_clr_i & ready_clear_mode_i);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !buffer_valid_i || pointer_rewind_ok) begin
            seen <= 1'b0;
        end else if (rx_done && !sel.ready_timing_mode) begin
            seen <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            buffer_ready_flag_o <= 1'b0;
        end else if (rdy_set) begin
            buffer_ready_flag_o <= 1'b1; // set beats clear
        end else if (rdy_clr) begin
            buffer_ready_flag_o <= 1'b0;
        end
    end
endmodule

// ==== dfps_assertions.sv ====
module dfps_assertions (
    input logic clk_i,
    input logic sys_rst_i,
    input logic req,
    input logic rd_n,
    input logic wr_n,
    input logic cs_n,
    input logic tc,
    input logic h_oe,
    input logic d_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] idle_cnt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // cycles since the far end last selected the port
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !cs_n) begin
            idle_cnt <= 4'h0;
        end else if (idle_cnt != 4'hf) begin
            idle_cnt <= idle_cnt + 4'h1;
        end
    end

    chk_bus_exclusive: assert property (!(d_oe && h_oe))
        else $error("both ends drive the data bus");
    chk_dev_drive_frame: assert property (d_oe |-> idle_cnt < 4'h4)
        else $error("device drives bus outside a selected cycle");
    chk_strobes_apart: assert property (!(!rd_n && !wr_n))
        else $error("read and write strobes low together");
    chk_reset_req_idle: assert property ($fell(sys_rst_i) |-> req)
        else $error("request active right after reset");
    chk_write_hold: assert property ($rose(wr_n) |-> h_oe [*3])
        else $error("write data released too early");
    chk_strobe_width: assert property ($fell(wr_n) |-> !wr_n [*5])
        else $error("write strobe too short");
    chk_tc_with_data: assert property (tc |-> h_oe)
        else $error("terminal count outside a write");
    chk_cs_frame: assert property ($fell(cs_n) |-> !cs_n [*4] ##1 (##[0:8] cs_n))
        else $error("select frame length wrong");
    chk_read_ends: assert property ($rose(d_oe) |-> ##[1:8] !d_oe)
        else $error("device read drive does not end");

    // main traffic kinds
    cov_read: cover property ($rose(d_oe));
    cov_tc_write: cover property ($rose(wr_n) && tc);
    cov_req_drop: cover property ($rose(req));
endmodule

// ==== dfps_bench.sv ====
module dfps_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, sys_rst_i = 1, reg_we_i = 0, buffer_valid_i = 0, rcm = 0, tx_ready_i = 0;
    logic req_pol_i = 0, ack_pol_i = 0, cmd_valid_i = 0, cmd_write_i = 0, cmd_last_i = 0;
    logic [7:0] reg_addr_i = 8'h48;
    logic [15:0] reg_wdata_i = 16'h0000, rx_data_i = 16'hc3a5, cmd_data_i = 16'h0000;
    logic [6:0] ep_dir_i = 7'h7e;
    logic [6:0] ep_narrow_i = 7'h00;
    logic [2:0] evt_i = 3'h0;
    logic [15:0] reg_rdata_o, rsp_data_o, rsp_word;
    logic flag_o, wdone_o, rewind_o, tx_valid_o, cmd_ready_o, rsp_valid_o, rxr_o;
    logic done_seen = 0, rwd_seen = 0, drop_seen = 0;
    logic [16:0] tx_data_o;
    logic [16:0] exp_q[$];
    int err_total = 0, total_checks = 0, cyc = 0, rxr_cnt = 0;

    dfps_if lnk_if();
    dfps_dev #(.PORT(0), .MAXP(64), .FDEPTH(8)) dfps_dev_i (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .lnk(lnk_if), .reg_we_i(reg_we_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .ep_dir_i(ep_dir_i),
        .ep_narrow_i(ep_narrow_i), .buffer_valid_i(buffer_valid_i),
        .port_receive_length_i(11'h004),
        .buffer_clear_i(evt_i[0]), .ready_clear_mode_i(rcm), .ready_flag_clr_i(evt_i[1]),
        .sie_ready_evt_i(evt_i[2]), .buffer_ready_flag_o(flag_o), .write_done_o(wdone_o),
        .rewind_o(rewind_o), .rx_data_i(rx_data_i), .rx_ready_o(rxr_o), .tx_valid_o(tx_valid_o),
        .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o));
    dfps_host dfps_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lnk(lnk_if),
        .ack_pol_i(ack_pol_i), .req_pol_i(req_pol_i), .cmd_valid_i(cmd_valid_i),
        .cmd_write_i(cmd_write_i), .cmd_data_i(cmd_data_i), .cmd_last_i(cmd_last_i),
        .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));
    dfps_assertions dfps_assertions_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req(lnk_if.req),
        .rd_n(lnk_if.rd_n), .wr_n(lnk_if.wr_n), .cs_n(lnk_if.cs_n), .tc(lnk_if.tc),
        .h_oe(lnk_if.h_oe), .d_oe(lnk_if.d_oe));

    // clock, cycle ceiling and capture of pulsed outputs
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (wdone_o) done_seen <= 1;
        if (rewind_o) rwd_seen <= 1;
        if (rsp_valid_o) rsp_word <= rsp_data_o;
        if (rxr_o) rxr_cnt <= rxr_cnt + 1;
        // request seen inactive inside a selected frame (low-active request)
        if (!lnk_if.cs_n && lnk_if.req) drop_seen <= 1;
        if (cyc == 5000) begin
            err_total++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] v);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_we_i <= 1;
        tk(1);
        reg_we_i <= 0;
        tk(1);
    endtask
    task automatic pls(input logic [2:0] v);
        evt_i <= v;
        tk(1);
        evt_i <= 3'h0;
        tk(2);
    endtask
    // select value: method, byte order, narrow, ready mode, endpoint; enabled
    function automatic logic [15:0] cfg(input logic [1:0] m, input logic b, input logic n,
        input logic i, input logic [3:0] ep);
        return {1'b0, m, 3'h0, i, 1'b1, b, n, 2'h0, ep};
    endfunction
    // one far end transfer, then a fixed 14-cycle wait that covers the 10 cycles it takes
    task automatic hop(input logic w, input logic [15:0] d, input logic l);
        cmd_write_i <= w;
        cmd_data_i <= d;
        cmd_last_i <= l;
        cmd_valid_i <= 1;
        for (int k = 0; k < 20; k++) begin
            @(negedge clk_i);
            if (cmd_ready_o === 1'b1) break;
        end
        @(posedge clk_i);
        cmd_valid_i <= 0;
        tk(14);
    endtask
    task automatic put(input logic [15:0] c, input logic [15:0] d, input logic l,
        input logic [16:0] e, input logic ok);
        wreg(8'h48, c);
        hop(1, d, l);
        if (ok) exp_q.push_back(e);
    endtask

    task automatic t_regs();
        chk("select reset", 17'h0, {1'b0, reg_rdata_o});
        chk("req idle", 17'h1, {16'h0, lnk_if.req});
        wreg(8'h48, 16'hffff);
        chk("select bits", 17'h0efcf, {1'b0, reg_rdata_o});
        wreg(8'h4a, 16'h0000);
        chk("unmapped", 17'h0, {1'b0, reg_rdata_o});
        reg_addr_i <= 8'h48;
        tk(1);
        chk("select kept", 17'h0efcf, {1'b0, reg_rdata_o});
        wreg(8'h48, cfg(2'h0, 0, 0, 0, 4'h1));
        tk(3);
        chk("req low active", 17'h0, {16'h0, lnk_if.req});
        req_pol_i <= 1;
        wreg(8'h48, cfg(2'h0, 0, 0, 0, 4'h1) | 16'h0400);
        tk(3);
        chk("req high active", 17'h1, {16'h0, lnk_if.req});
        req_pol_i <= 0;
    endtask
    task automatic t_fill();
        for (int m = 0; m < 4; m++) begin
            put(cfg(m[1:0], 0, 0, 0, 4'h1), 16'h1200 | 16'(m), 0,
                17'h1200 | 17'(m), m != 3);
        end
        put(cfg(2'h0, 1, 0, 0, 4'h1), 16'h1234, 0, 17'h03412, 1);
        put(cfg(2'h0, 0, 1, 0, 4'h1), 16'h55aa, 0, 17'h100aa, 1);
        // receive endpoint with data waiting, so the far end really writes
        ep_dir_i <= 7'h00;
        buffer_valid_i <= 1;
        pls(3'h1);
        put(cfg(2'h0, 0, 0, 0, 4'h1), 16'h0bad, 0, 17'h0, 0);
        buffer_valid_i <= 0;
        ep_dir_i <= 7'h7e;
        put(cfg(2'h0, 0, 0, 0, 4'h0), 16'h0bad, 0, 17'h0, 0);
        done_seen <= 0;
        for (int k = 0; k < 4; k++) begin
            put(cfg(2'h0, 0, 0, 0, 4'h1), 16'h7000 | 16'(k), k == 2, 17'h7000 | 17'(k), k < 3);
        end
        chk("tc completion", 17'h1, {16'h0, done_seen});
        tx_ready_i <= 1;
        for (int i = 0; i < 40 && exp_q.size() > 0; i++) begin
            @(negedge clk_i);
            if (tx_valid_o === 1'b1) chk("fifo word", exp_q.pop_front(), tx_data_o);
        end
        @(posedge clk_i);
        tx_ready_i <= 0;
        @(negedge clk_i);
        chk("fifo empty", 17'h0, {16'h0, tx_valid_o});
        chk("words left", 17'h0, 17'(exp_q.size()));
        // high-active acknowledge in burst, pins settled before the method change
        ack_pol_i <= 1;
        drop_seen <= 0;
        tk(3);
        put(cfg(2'h1, 0, 0, 0, 4'h1) | 16'h8800, 16'h4321, 0, 17'h0, 0);
        chk("burst held", 17'h0, {16'h0, drop_seen});
        ack_pol_i <= 0;
        ep_narrow_i <= 7'h02;
        drop_seen <= 0;
        put(cfg(2'h0, 0, 0, 0, 4'h1), 16'h66bb, 0, 17'h0, 0);
        ep_narrow_i <= 7'h00;
        chk("steal drop", 17'h1, {16'h0, drop_seen});
        @(negedge clk_i);
        chk("ack high word", 17'h04321, tx_data_o);
        @(posedge clk_i);
        tx_ready_i <= 1;
        @(posedge clk_i);
        tx_ready_i <= 0;
        @(negedge clk_i);
        chk("narrow endpoint", 17'h100bb, tx_data_o);
    endtask
    task automatic t_read();
        ep_dir_i <= 7'h00;
        buffer_valid_i <= 1;
        pls(3'h1);
        wreg(8'h48, cfg(2'h0, 0, 0, 0, 4'h1));
        hop(0, 16'h0, 0);
        chk("read word", 17'h0c3a5, {1'b0, rsp_word});
        chk("flag early", 17'h0, {16'h0, flag_o});
        hop(0, 16'h0, 0);
        tk(3);
        chk("flag after all", 17'h1, {16'h0, flag_o});
        chk("words taken", 17'h2, 17'(rxr_cnt));
        rwd_seen <= 0;
        wreg(8'h48, cfg(2'h0, 0, 0, 0, 4'h1) | 16'h1000);
        tk(1);
        chk("rewind", 17'h1, {16'h0, rwd_seen});
        pls(3'h1);
        chk("flag cleared", 17'h0, {16'h0, flag_o});
        ep_dir_i <= 7'h7e;
        buffer_valid_i <= 0;
        hop(0, 16'h0, 0);
        chk("transmit read", 17'h0, {1'b0, rsp_word});
    endtask
    task automatic t_mode();
        rcm <= 1;
        wreg(8'h48, cfg(2'h0, 0, 0, 1, 4'h1));
        pls(3'h4);
        chk("mode1 set", 17'h1, {16'h0, flag_o});
        pls(3'h1);
        chk("mode1 held", 17'h1, {16'h0, flag_o});
        pls(3'h2);
        chk("mode1 clear", 17'h0, {16'h0, flag_o});
        wreg(8'h48, cfg(2'h0, 0, 0, 0, 4'h1));
        pls(3'h4);
        chk("mode0 transmit", 17'h0, {16'h0, flag_o});
    endtask

    // main sequence
    initial begin
        tk(2);
        sys_rst_i <= 0;
        tk(1);
        t_regs();
        t_fill();
        t_read();
        t_mode();
        summarize();
    end
endmodule
